/* File: hdl/plc_pkg.sv */
// constants for one switch port's link capability and link control words.
// assumes a dword config access port and same-clock link training logic.
//
// Operation
// RULE_01 - max speed read-only, resets to 5.0 Gb/s
// RULE_02 - max width x4 wide upstream, else x1
// RULE_03 - aspm support field resets 00b, loadable
// RULE_04 - l0s exit latency resets 011b, loadable
// RULE_05 - l1 exit latency resets 000b, loadable
// RULE_06 - clock pm capable: upstream 1, downstream 0
// RULE_07 - dl active reporting: downstream 1, upstream 0
// RULE_08 - bandwidth notify capability resets 0, loadable
// RULE_09 - top byte is port number, loadable
// RULE_10 - writable aspm control field, resets 00b
// RULE_11 - receiver may always enter l0s
// RULE_12 - read completion boundary always reads 0
// RULE_13 - link disable only on downstream ports
// RULE_14 - retrain write starts training, reads 0; upstream ports ignore the write
// RULE_15 - writable common clock bit, resets 0
// RULE_16 - extended synch sends 4096 fts, 1024 ts1
// RULE_17 - clkpm off holds clkreq low; upstream only
// RULE_18 - bandwidth irq enables writable downstream only
// RULE_19 - training flag set until hardware completes training
// RULE_20 - one register instance per port, role chosen

package plc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // access port and offsets
   localparam int CFG_AW = 12;
   localparam logic [11:0] LINK_CAP_OFF = 12'h0cc;
   localparam logic [11:0] LINK_CTL_OFF = 12'h0d0;

   ////////////////////////////////////////////////////////////////////////
   // capability word fields
   localparam int CAP_SPEED_LSB = 0;
   localparam int CAP_SPEED_MSB = 3;
   localparam int CAP_WIDTH_LSB = 4;
   localparam int CAP_WIDTH_MSB = 9;
   localparam int CAP_DLLRPT = 20;
   localparam int CAP_CLKPM = 18;
   localparam int CAP_RSVD_LSB = 22;
   localparam int CAP_RSVD_MSB = 23;
   // bits that serial-bus or eeprom loading may replace
   localparam logic [31:0] CAP_LOAD_MASK = 32'hff2ffc00;

   // capability reset values
   localparam logic [3:0] SPEED_2G5 = 4'h1;
   localparam logic [3:0] SPEED_5G = 4'h2;
   localparam logic [5:0] WIDTH_X4 = 6'h04;
   localparam logic [5:0] WIDTH_X1 = 6'h01;
   localparam logic [1:0] ASPM_SUP_RST = 2'h0;
   localparam logic [2:0] L0S_LAT_RST = 3'h3;
   localparam logic [2:0] L1_LAT_RST = 3'h0;
   localparam logic CLKPM_CAP_US_RST = 1'b1;
   localparam logic SURPRISE_RST = 1'b0;
   localparam logic DLL_RPT_DS_RST = 1'b1;
   localparam logic BW_NOTIFY_RST = 1'b0;

   ////////////////////////////////////////////////////////////////////////
   // control word fields, training flag in the status half of the dword
   localparam int CTL_ASPM_LSB = 0;
   localparam int CTL_ASPM_MSB = 1;
   localparam int CTL_RCB = 3;
   localparam int CTL_LDIS = 4;
   localparam int CTL_RETRAIN = 5;
   localparam int CTL_CCLK = 6;
   localparam int CTL_EXTSYNC = 7;
   localparam int CTL_CLKPM = 8;
   localparam int CTL_HAWD = 9;
   localparam int CTL_BWMIE = 10;
   localparam int CTL_LABIE = 11;
   localparam int STS_LTRAIN = 27;
   localparam logic [1:0] ASPM_OFF = 2'h0;
   localparam logic [1:0] ASPM_L0S = 2'h1;
   localparam logic [1:0] ASPM_L1 = 2'h2;
   localparam logic [1:0] ASPM_BOTH = 2'h3;

   ////////////////////////////////////////////////////////////////////////
   // ordered-set counts on exit from low-power states
   localparam int OS_CW = 13;
   localparam logic [12:0] EXT_FTS_COUNT = 13'h1000;
   localparam logic [12:0] EXT_TS1_COUNT = 13'h0400;
   localparam logic [12:0] NORM_FTS_COUNT = 13'h0020;
   localparam logic [12:0] NORM_TS1_COUNT = 13'h0010;

   ////////////////////////////////////////////////////////////////////////
   // state encodings
   typedef enum logic [2:0] {
      TR_TRAIN = 3'h1,
      TR_ACTIVE = 3'h2,
      TR_DISABLED = 3'h4
   } plc_train_e;

   typedef enum logic [1:0] {
      OS_IDLE = 2'h1,
      OS_SEND = 2'h2
   } plc_os_e;

endpackage

/* File: hdl/plc_os_seq.sv */
// ordered-set sequencer for exits from l0s and l1 toward l0.
// assumes the transmit side takes one ordered set per cycle of os_ready.
`timescale 1ns/1ps

module plc_os_seq (
   input logic ref_clk,
   input logic rst,
   input logic ce,
   input logic ext_synch,
   input logic exit_l0s_req,
   input logic exit_l1_req,
   input logic os_ready,
   output logic os_valid,
   output logic os_is_ts1,
   output logic exit_done
);
   import plc_pkg::*;

   plc_os_e state, next_state;
   logic [OS_CW-1:0] remain, next_remain;
   logic is_ts1, next_is_ts1;
   logic done, next_done;

   ////////////////////////////////////////////////////////////////////////
   // next state; l1 wins if both exits are asked in one cycle
   always_comb begin
      next_state = state;
      next_remain = remain;
      next_is_ts1 = is_ts1;
      next_done = 1'b0;
      case (state)
         OS_IDLE: begin
            if (exit_l1_req) begin
               next_state = OS_SEND;
               next_is_ts1 = 1'b1;
               next_remain = ext_synch ? EXT_TS1_COUNT : NORM_TS1_COUNT; // RULE_16
            end else if (exit_l0s_req) begin
               next_state = OS_SEND;
               next_is_ts1 = 1'b0;
               next_remain = ext_synch ? EXT_FTS_COUNT : NORM_FTS_COUNT; // RULE_16
            end
         end
         OS_SEND: begin
            // new exit requests are ignored until the burst ends
            if (os_ready) begin
               next_remain = remain - 13'h0001;
               if (remain == 13'h0001) begin
                  next_state = OS_IDLE;
                  next_done = 1'b1;
               end
            end
         end
         default: begin
            next_state = OS_IDLE;
         end
      endcase
   end

   // registers, frozen while ce is low
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state <= OS_IDLE;
         remain <= 13'h0000;
         is_ts1 <= 1'b0;
         done <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         remain <= next_remain;
         is_ts1 <= next_is_ts1;
         done <= next_done;
      end
   end

   assign os_valid = (state == OS_SEND);
   assign os_is_ts1 = is_ts1;
   assign exit_done = done;

endmodule // plc_os_seq

/* File: hdl/plc_link_regs.sv */
// one switch port's link capability and link control registers.
// assumes one instance per port; training logic and pm logic on ref_clk.
`timescale 1ns/1ps

module plc_link_regs #(
   parameter logic [7:0] PORT_INDEX = 8'h00,
   parameter logic IS_UPSTREAM = 1'b1,
   parameter logic WIDE_UPSTREAM = 1'b0
) (
   input logic ref_clk,
   input logic rst,
   input logic ce,
   // config access
   input logic cfg_req,
   input logic cfg_wr,
   input logic [plc_pkg::CFG_AW-1:0] cfg_addr,
   input logic [3:0] cfg_be,
   input logic [31:0] cfg_wdata,
   output logic cfg_ack,
   output logic [31:0] cfg_rdata,
   // default load from serial bus or eeprom
   input logic load_req,
   input logic [31:0] load_data,
   // link training and low-power exits
   input logic training_done,
   input logic exit_l0s_req,
   input logic exit_l1_req,
   input logic os_ready,
   output logic os_valid,
   output logic os_is_ts1,
   output logic exit_done,
   output logic retrain_start,
   output logic link_disable,
   output logic link_training,
   // reference clock request pin
   input logic clkpm_off_req,
   input logic clkreq_n_i,
   output logic clkreq_n_o,
   output logic clkreq_n_oe,
   output logic refclk_removable,
   // control levels toward the port
   output logic aspm_l0s_en,
   output logic aspm_l1_en,
   output logic rx_l0s_capable,
   output logic common_clock,
   output logic hw_width_disable,
   output logic bw_mgmt_ie,
   output logic auto_bw_ie
);
   import plc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // helpers

   // dword address match, shared by read and write decode
   function automatic logic addr_hit(input logic [CFG_AW-1:0] a,
                                     input logic [CFG_AW-1:0] off);
      addr_hit = (a[CFG_AW-1:2] == off[CFG_AW-1:2]);
   endfunction

   // fields that no load may change, applied at reset and on each load
   function automatic logic [31:0] cap_role_fix(input logic [31:0] raw);
      logic [31:0] v;
      v = raw;
      v[CAP_SPEED_MSB:CAP_SPEED_LSB] = SPEED_5G; // RULE_01
      if (IS_UPSTREAM && WIDE_UPSTREAM) begin
         v[CAP_WIDTH_MSB:CAP_WIDTH_LSB] = WIDTH_X4; // RULE_02
      end else begin
         v[CAP_WIDTH_MSB:CAP_WIDTH_LSB] = WIDTH_X1; // RULE_02
      end
      if (!IS_UPSTREAM) begin
         v[CAP_CLKPM] = 1'b0; // RULE_06
         v[CAP_DLLRPT] = DLL_RPT_DS_RST; // RULE_07
      end else begin
         v[CAP_DLLRPT] = 1'b0; // RULE_07
      end
      v[CAP_RSVD_MSB:CAP_RSVD_LSB] = 2'h0;
      return v;
   endfunction

   // reset image of the capability word, port index in the top byte
   localparam logic [31:0] CAP_RESET_RAW = {
      PORT_INDEX, // RULE_09
      2'h0,
      BW_NOTIFY_RST, // RULE_08
      DLL_RPT_DS_RST,
      SURPRISE_RST,
      CLKPM_CAP_US_RST, // RULE_06
      L1_LAT_RST, // RULE_05
      L0S_LAT_RST, // RULE_04
      ASPM_SUP_RST, // RULE_03
      WIDTH_X1,
      SPEED_2G5
   };

   ////////////////////////////////////////////////////////////////////////
   // state declarations
   logic [31:0] cap, next_cap;
   logic [1:0] aspm_ctl, next_aspm_ctl;
   logic ldis, next_ldis;
   logic cclk, next_cclk;
   logic extsync, next_extsync;
   logic clkpm_en, next_clkpm_en;
   logic hawd, next_hawd;
   logic bwmie, next_bwmie;
   logic labie, next_labie;
   logic retrain_q, next_retrain_q;
   plc_train_e tstate, next_tstate;
   logic ack_q, next_ack_q;
   logic [31:0] rdata_q, next_rdata_q;
   logic clkreq_s1, clkreq_s2, clkreq_s3;
   logic clkreq_lvl, next_clkreq_lvl;
   logic clkreq_drive, next_clkreq_drive;
   logic removable_q, next_removable_q;
   logic wr_ctl, wr_b0, wr_b1, retrain_wr;
   logic [31:0] ctl_view;

   ////////////////////////////////////////////////////////////////////////
   // write decode; only the control half of the d0 dword takes writes
   assign wr_ctl = cfg_req && cfg_wr && addr_hit(cfg_addr, LINK_CTL_OFF);
   assign wr_b0 = wr_ctl && cfg_be[0];
   assign wr_b1 = wr_ctl && cfg_be[1];
   // retrain is a strobe, nothing is stored for it
   assign retrain_wr = wr_b0 && cfg_wdata[CTL_RETRAIN] && !IS_UPSTREAM; // RULE_14

   ////////////////////////////////////////////////////////////////////////
   // capability word: read-only to software, replaced by default loads
   always_comb begin
      next_cap = cap;
      if (load_req) begin
         next_cap = cap_role_fix((cap & ~CAP_LOAD_MASK) |
                                 (load_data & CAP_LOAD_MASK)); // RULE_03
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cap <= cap_role_fix(CAP_RESET_RAW); // RULE_20
      end else if (ce) begin
         cap <= next_cap;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control word fields, role gating on both port roles (clock pm upstream only, disable and irq enables downstream only)
   always_comb begin
      next_aspm_ctl = aspm_ctl;
      next_ldis = ldis;
      next_cclk = cclk;
      next_extsync = extsync;
      next_clkpm_en = clkpm_en;
      next_hawd = hawd;
      next_bwmie = bwmie;
      next_labie = labie;
      if (wr_b0) begin
         next_aspm_ctl = cfg_wdata[CTL_ASPM_MSB:CTL_ASPM_LSB]; // RULE_10
         next_ldis = cfg_wdata[CTL_LDIS] && !IS_UPSTREAM; // RULE_13
         next_cclk = cfg_wdata[CTL_CCLK]; // RULE_15
         next_extsync = cfg_wdata[CTL_EXTSYNC]; // RULE_16
      end
      if (wr_b1) begin
         next_clkpm_en = cfg_wdata[CTL_CLKPM] && IS_UPSTREAM; // RULE_17
         next_hawd = cfg_wdata[CTL_HAWD];
         // upstream keeps both enables at zero
         next_bwmie = cfg_wdata[CTL_BWMIE] && !IS_UPSTREAM; // RULE_18
         next_labie = cfg_wdata[CTL_LABIE] && !IS_UPSTREAM; // RULE_18
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         aspm_ctl <= ASPM_OFF; // RULE_10
         ldis <= 1'b0;
         cclk <= 1'b0;
         extsync <= 1'b0;
         clkpm_en <= 1'b0;
         hawd <= 1'b0;
         bwmie <= 1'b0;
         labie <= 1'b0;
      end else if (ce) begin
         aspm_ctl <= next_aspm_ctl;
         ldis <= next_ldis;
         cclk <= next_cclk;
         extsync <= next_extsync;
         clkpm_en <= next_clkpm_en;
         hawd <= next_hawd;
         bwmie <= next_bwmie;
         labie <= next_labie;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // training state; a link trains from reset, so the flag starts set
   always_comb begin
      next_tstate = tstate;
      next_retrain_q = 1'b0;
      case (tstate)
         TR_TRAIN: begin
            if (ldis) begin
               next_tstate = TR_DISABLED; // RULE_13
            end else if (retrain_wr) begin
               // a new request in the done cycle wins, training goes on
               next_retrain_q = 1'b1;
            end else if (training_done) begin
               next_tstate = TR_ACTIVE; // RULE_19
            end
         end
         TR_ACTIVE: begin
            if (ldis) begin
               next_tstate = TR_DISABLED; // RULE_13
            end else if (retrain_wr) begin
               next_tstate = TR_TRAIN; // RULE_19
               next_retrain_q = 1'b1; // RULE_14
            end
         end
         TR_DISABLED: begin
            // clearing the disable bit brings the link up afresh
            if (!ldis) begin
               next_tstate = TR_TRAIN;
            end
         end
         default: begin
            next_tstate = TR_TRAIN;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tstate <= TR_TRAIN;
         retrain_q <= 1'b0;
      end else if (ce) begin
         tstate <= next_tstate;
         retrain_q <= next_retrain_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read view of the d0 dword: control low, training flag high
   always_comb begin
      ctl_view = 32'h00000000;
      ctl_view[CTL_ASPM_MSB:CTL_ASPM_LSB] = aspm_ctl;
      ctl_view[CTL_RCB] = 1'b0; // RULE_12
      ctl_view[CTL_LDIS] = ldis;
      ctl_view[CTL_RETRAIN] = 1'b0; // RULE_14
      ctl_view[CTL_CCLK] = cclk;
      ctl_view[CTL_EXTSYNC] = extsync;
      ctl_view[CTL_CLKPM] = clkpm_en;
      ctl_view[CTL_HAWD] = hawd;
      ctl_view[CTL_BWMIE] = bwmie;
      ctl_view[CTL_LABIE] = labie;
      ctl_view[STS_LTRAIN] = (tstate == TR_TRAIN); // RULE_19
   end

   // config answer one cycle after the request; unmapped reads give zero
   always_comb begin
      next_ack_q = cfg_req;
      next_rdata_q = rdata_q;
      if (cfg_req && !cfg_wr) begin
         if (addr_hit(cfg_addr, LINK_CAP_OFF)) begin
            next_rdata_q = cap;
         end else if (addr_hit(cfg_addr, LINK_CTL_OFF)) begin
            next_rdata_q = ctl_view;
         end else begin
            next_rdata_q = 32'h00000000;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end else if (ce) begin
         ack_q <= next_ack_q;
         rdata_q <= next_rdata_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // clkreq pin: three-stage sync, level taken once stages two and three agree
   always_comb begin
      next_clkreq_lvl = clkreq_lvl;
      if (clkreq_s2 == clkreq_s3) begin
         next_clkreq_lvl = clkreq_s3;
      end
      // with clock pm off the pin is pulled low without exception
      next_clkreq_drive = !(clkpm_en && clkpm_off_req); // RULE_17
      next_removable_q = clkpm_en && clkreq_lvl && cap[CAP_CLKPM];
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         clkreq_s1 <= 1'b0;
         clkreq_s2 <= 1'b0;
         clkreq_s3 <= 1'b0;
         clkreq_lvl <= 1'b0;
         clkreq_drive <= 1'b1;
         removable_q <= 1'b0;
      end else if (ce) begin
         clkreq_s1 <= clkreq_n_i;
         clkreq_s2 <= clkreq_s1;
         clkreq_s3 <= clkreq_s2;
         clkreq_lvl <= next_clkreq_lvl;
         clkreq_drive <= next_clkreq_drive;
         removable_q <= next_removable_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // exit sequencer, ordered-set count chosen by extended synch
   plc_os_seq u_os_seq (
      .ref_clk(ref_clk),
      .rst(rst),
      .ce(ce),
      .ext_synch(extsync),
      .exit_l0s_req(exit_l0s_req),
      .exit_l1_req(exit_l1_req),
      .os_ready(os_ready),
      .os_valid(os_valid),
      .os_is_ts1(os_is_ts1),
      .exit_done(exit_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign cfg_ack = ack_q;
   assign cfg_rdata = rdata_q;
   assign retrain_start = retrain_q;
   assign link_disable = ldis;
   assign link_training = (tstate == TR_TRAIN);
   assign clkreq_n_o = 1'b0; // open drain, only ever pulls low
   assign clkreq_n_oe = clkreq_drive;
   assign refclk_removable = removable_q;
   assign aspm_l0s_en = aspm_ctl[0];
   assign aspm_l1_en = aspm_ctl[1];
   // receive side l0s entry does not depend on the aspm field
   assign rx_l0s_capable = 1'b1; // RULE_11
   assign common_clock = cclk;
   assign hw_width_disable = hawd;
   assign bw_mgmt_ie = bwmie;
   assign auto_bw_ie = labie;

endmodule // plc_link_regs

/* File: dv/plc_link_chk_sva.sv */
// checker for one port's link capability and control block.
// assumes a bind onto plc_link_regs and the single ref_clk domain.
`timescale 1ns/1ps

module plc_link_chk #(
   parameter logic IS_UPSTREAM = 1'b1
) (
   input logic ref_clk,
   input logic rst,
   input logic ce,
   input logic cfg_req,
   input logic cfg_wr,
   input logic [plc_pkg::CFG_AW-1:0] cfg_addr,
   input logic cfg_ack,
   input logic [31:0] cfg_rdata,
   input logic exit_l0s_req,
   input logic exit_l1_req,
   input logic os_valid,
   input logic os_is_ts1,
   input logic exit_done,
   input logic retrain_start,
   input logic link_disable,
   input logic link_training,
   input logic clkreq_n_o,
   input logic clkreq_n_oe,
   input logic refclk_removable,
   input logic rx_l0s_capable
);
   import plc_pkg::*;

   logic req_q, next_req_q, rdc_q, next_rdc_q;

   ////////////////////////////////////////////////////////////////////////
   // helper: remember a taken request and whether it read the ctl dword
   always_comb begin
      next_req_q = cfg_req && ce && !rst;
      next_rdc_q = next_req_q && !cfg_wr &&
         (cfg_addr[11:2] == LINK_CTL_OFF[11:2]);
   end
   always_ff @(posedge ref_clk) begin
      req_q <= next_req_q;
      rdc_q <= next_rdc_q;
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////
   // burst end: valid drops, so the exit must be flagged in that cycle
   sequence s_burst_end;
      os_valid ##1 !os_valid;
   endsequence
   sequence s_exit_taken;
      !os_valid && !exit_done && (exit_l0s_req || exit_l1_req);
   endsequence

   AST_ACK: assert property (cfg_ack == req_q)
      else $error("config answer not one cycle after request");
   AST_RCB_RETRAIN_RD0: assert property (rdc_q |-> !cfg_rdata[3] &&
      !cfg_rdata[5])
      else $error("ctl read shows boundary or retrain bit set");
   AST_RETRAIN_CAUSE: assert property (retrain_start |->
      $past(cfg_req) && $past(cfg_wr) && !IS_UPSTREAM)
      else $error("retrain pulse without a downstream write");
   AST_TRAIN_FLAG: assert property (retrain_start |-> link_training)
      else $error("training flag low while retrain starts");
   AST_LDIS: assert property (link_disable ##1 link_disable |->
      !link_training && !IS_UPSTREAM)
      else $error("disabled link still training or upstream disable");
   AST_RXL0S: assert property (rx_l0s_capable)
      else $error("receiver l0s capability dropped");
   AST_CLKREQ: assert property (!clkreq_n_o && (IS_UPSTREAM ||
      (clkreq_n_oe && !refclk_removable)))
      else $error("clock request pin not held low");
   AST_OS_START: assert property (s_exit_taken |=> os_valid &&
      (os_is_ts1 == $past(exit_l1_req)))
      else $error("exit burst did not start with right set kind");
   AST_OS_DONE: assert property (s_burst_end |-> exit_done)
      else $error("burst ended without exit pulse");

endmodule // plc_link_chk

/* File: dv/plc_link_partner.sv */
// far-side link partner: finishes training, takes ordered sets.
// assumes the clock request line has a pull-up when nobody drives it.
`timescale 1ns/1ps

module plc_link_partner #(
   parameter logic [7:0] TRAIN_CYC = 8'h14
) (
   input logic ref_clk,
   input logic rst,
   input logic slow,
   input logic link_training,
   input logic clkreq_n_o,
   input logic clkreq_n_oe,
   output logic training_done,
   output logic os_ready,
   output logic clkreq_n_i
);
   logic [7:0] cnt, next_cnt;
   logic next_done, next_rdy;

   ////////////////////////////////////////////////////////////////////////
   // training takes a while; slow mode stalls every other ordered set
   always_comb begin
      next_cnt = (link_training && !training_done) ? cnt + 8'h01 : 8'h00;
      next_done = link_training && (cnt == TRAIN_CYC);
      next_rdy = slow ? !os_ready : 1'b1;
   end
   always_ff @(posedge ref_clk) begin
      cnt <= rst ? 8'h00 : next_cnt;
      training_done <= !rst && next_done;
      os_ready <= !rst && next_rdy;
   end

   // released pin floats up to the pull-up level
   assign clkreq_n_i = clkreq_n_oe ? clkreq_n_o : 1'b1;

endmodule // plc_link_partner

/* File: dv/testbench.sv */
// self-checking bench for one downstream port's link registers.
// assumes partner model and checker files compiled before this one.
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
   miscompares++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module testbench;
   import plc_pkg::*;

   logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, cfg_req = 1'b0;
   logic cfg_wr = 1'b0, load_req = 1'b0, exit_l0s_req = 1'b0;
   logic exit_l1_req = 1'b0, slow = 1'b0, clkpm_off_req = 1'b0;
   logic [11:0] cfg_addr = 12'h000;
   logic [3:0] cfg_be = 4'h0;
   logic [31:0] cfg_wdata = 32'h0, load_data = 32'h0, cfg_rdata;
   logic cfg_ack, training_done, os_ready, os_valid, os_is_ts1, exit_done;
   logic retrain_start, link_disable, link_training, clkreq_n_i;
   logic clkreq_n_o, clkreq_n_oe, aspm_l0s_en, aspm_l1_en, rx_l0s_capable;
   logic common_clock, hw_width_disable, bw_mgmt_ie, auto_bw_ie;
   int miscompares = 0, cmp_count = 0, cyc = 0;
   localparam logic [31:0] CAP_RST = {8'h05, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0,
      L1_LAT_RST, L0S_LAT_RST, ASPM_SUP_RST, WIDTH_X1, SPEED_5G};

   always #2 ref_clk = !ref_clk;

   plc_link_regs #(.PORT_INDEX(8'h05), .IS_UPSTREAM(1'b0),
      .WIDE_UPSTREAM(1'b0)) plc_link_regs_i (.ref_clk, .rst, .ce,
      .cfg_req, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_ack,
      .cfg_rdata, .load_req, .load_data, .training_done, .exit_l0s_req,
      .exit_l1_req, .os_ready, .os_valid, .os_is_ts1, .exit_done,
      .retrain_start, .link_disable, .link_training,
      .clkpm_off_req, .clkreq_n_i, .clkreq_n_o, .clkreq_n_oe,
      .refclk_removable(), .aspm_l0s_en, .aspm_l1_en, .rx_l0s_capable,
      .common_clock, .hw_width_disable, .bw_mgmt_ie, .auto_bw_ie);

   plc_link_partner plc_link_partner_i (.ref_clk, .rst, .slow,
      .link_training, .clkreq_n_o, .clkreq_n_oe, .training_done,
      .os_ready, .clkreq_n_i);

   ////////////////////////////////////////////////////////////////////////
   // one config access; answer is looked at in its single ack cycle
   task automatic cfg(input logic wr, input logic [11:0] addr,
      input logic [3:0] be, input logic [31:0] wd);
      @(posedge ref_clk);
      cfg_req <= 1'b1;
      cfg_wr <= wr;
      cfg_addr <= addr;
      cfg_be <= be;
      cfg_wdata <= wd;
      @(posedge ref_clk);
      cfg_req <= 1'b0;
      #1;
   endtask

   // bounded wait for the partner to finish training
   task automatic wait_trained();
      for (int i = 0; i < 200 && link_training !== 1'b0; i++) begin
         @(posedge ref_clk);
         #1;
      end
      `CHK(link_training, 1'b0)
   endtask

   task automatic t_cap();
      cfg(1'b0, LINK_CAP_OFF, 4'hf, 32'h0);
      `CHK(cfg_rdata, CAP_RST)
      cfg(1'b1, LINK_CAP_OFF, 4'hf, 32'hffffffff);
      cfg(1'b0, LINK_CAP_OFF, 4'hf, 32'h0);
      `CHK(cfg_rdata, CAP_RST)
      cfg(1'b0, 12'h100, 4'hf, 32'h0);
      `CHK(cfg_rdata, 32'h0)
      @(posedge ref_clk);
      load_req <= 1'b1;
      load_data <= 32'hffffffff;
      @(posedge ref_clk);
      load_req <= 1'b0;
      // speed, width, dl reporting keep reset; bit 18 stays 0 downstream
      cfg(1'b0, LINK_CAP_OFF, 4'hf, 32'h0);
      `CHK(cfg_rdata, 32'hff3bfc12)
      $display("test cap done");
   endtask

   task automatic t_ctl();
      wait_trained();
      for (int c = 0; c < 4; c++) begin
         cfg(1'b1, LINK_CTL_OFF, 4'h1, 32'(c));
         cfg(1'b0, LINK_CTL_OFF, 4'hf, 32'h0);
         `CHK(cfg_rdata[1:0], 2'(c))
         `CHK({aspm_l1_en, aspm_l0s_en}, 2'(c))
         `CHK(rx_l0s_capable, 1'b1)
      end
      cfg(1'b1, LINK_CTL_OFF, 4'h3, 32'h00000fcb);
      cfg(1'b0, LINK_CTL_OFF, 4'hf, 32'h0);
      `CHK(cfg_rdata, 32'h00000ec3)
      `CHK({auto_bw_ie, bw_mgmt_ie, common_clock, link_disable}, 4'he)
      `CHK({hw_width_disable, clkreq_n_oe}, 2'h3)
      $display("test ctl done");
   endtask

   task automatic t_retrain();
      cfg(1'b1, LINK_CTL_OFF, 4'h1, 32'h00000020);
      `CHK({retrain_start, link_training}, 2'h3)
      cfg(1'b0, LINK_CTL_OFF, 4'hf, 32'h0);
      `CHK({cfg_rdata[27], cfg_rdata[5]}, 2'h2)
      wait_trained();
      cfg(1'b0, LINK_CTL_OFF, 4'hf, 32'h0);
      `CHK(cfg_rdata[27], 1'b0)
      cfg(1'b1, LINK_CTL_OFF, 4'h1, 32'h00000010);
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK({link_disable, link_training}, 2'h2)
      cfg(1'b1, LINK_CTL_OFF, 4'h1, 32'h0);
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK({link_disable, link_training}, 2'h1)
      wait_trained();
      $display("test retrain done");
   endtask

   // four exit kinds: fts or ts1, normal or extended; ts1 runs stalled
   task automatic t_os();
      logic [12:0] n, exp;
      logic ts1;
      for (int k = 0; k < 4; k++) begin
         n = 13'h0;
         exp = k[0] ? (k[1] ? EXT_TS1_COUNT : NORM_TS1_COUNT) :
            (k[1] ? EXT_FTS_COUNT : NORM_FTS_COUNT);
         cfg(1'b1, LINK_CTL_OFF, 4'h1, {24'h0, k[1], 7'h0});
         @(posedge ref_clk);
         slow <= k[0];
         exit_l1_req <= k[0];
         exit_l0s_req <= !k[0];
         @(posedge ref_clk);
         exit_l1_req <= 1'b0;
         exit_l0s_req <= 1'b0;
         #1;
         ts1 = os_is_ts1;
         for (int i = 0; i < 9000 && exit_done !== 1'b1; i++) begin
            if (os_valid === 1'b1 && os_ready === 1'b1)
               n = n + 13'h1;
            @(posedge ref_clk);
            #1;
         end
         `CHK(exit_done, 1'b1)
         `CHK(n, exp)
         `CHK(ts1, k[0])
      end
      $display("test exit bursts done");
   endtask

   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // hang guard: the longest burst pair needs about 6150 cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 30000) begin
         miscompares++;
         end_sim();
      end
   end

   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      // pm logic keeps asking for release; downstream must ignore it
      clkpm_off_req <= 1'b1;
      t_cap();
      t_ctl();
      t_retrain();
      t_os();
      end_sim();
   end

endmodule // testbench

bind plc_link_regs plc_link_chk #(.IS_UPSTREAM(IS_UPSTREAM)) plc_link_chk_i (
   .ref_clk, .rst, .ce, .cfg_req, .cfg_wr, .cfg_addr, .cfg_ack, .cfg_rdata,
   .exit_l0s_req, .exit_l1_req, .os_valid, .os_is_ts1, .exit_done,
   .retrain_start, .link_disable, .link_training, .clkreq_n_o,
   .clkreq_n_oe, .refclk_removable, .rx_l0s_capable);
